// *** rtl/digital_input_conditioning.sv ***
// digital input terminal conditioning: polarity, filter, delays, virtual mode, functions
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module digital_input_conditioning #(
  parameter int unsigned MS_CYCLES = dic_pkg::MS_CYCLES_DEF
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire dic_pkg::bus_req_t bus_i,
  output logic [31:0] rdata_o,
  input wire logic [7:0] switch_inputs_one_to_eight_i,
  input wire logic fast_pulse_input_i,
  output dic_pkg::func_out_t func_o,
  output logic [8:0] term_state_o,
  output dic_pkg::wire_mode_t run_wire_mode_o,
  output logic fast_input_type_o,
  output logic fast_pulse_o
);
  import dic_pkg::*;

  state_t s_reg;
  state_t s_next;

  // true when any active terminal carries the given function code
  function automatic logic code_active(input logic [8:0] act, input logic [8:0][6:0] sel,
                                       input logic [6:0] code);
    logic hit;
    hit = 1'h0;
    for (int k = 0; k < NUM_TERM; k++) begin
      if (act[k] && (sel[k] == code)) begin
        hit = 1'h1;
      end
    end
    return hit;
  endfunction

  // software may write past the top of a range; pin it to the limit
  function automatic logic [15:0] clamp_ms(input logic [31:0] v, input logic [15:0] lim);
    logic [15:0] r;
    if (v > {16'h0000, lim}) begin
      r = lim;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

  // address of the k-th word above a base
  function automatic logic [15:0] word_addr(input logic [15:0] base, input int k);
    logic [15:0] a;
    a = base + 16'(k) * ADDR_STRIDE;
    return a;
  endfunction

  // next state: sampling, conditioning, function decode and register access
  always_comb begin
    logic tick;
    logic src;
    logic raw;
    logic [15:0] dly;
    logic [31:0] rd;
    s_next = s_reg;
    tick = (s_reg.pre_cnt == 32'(MS_CYCLES - 1));
    src = 1'h0;
    raw = 1'h0;
    dly = 16'h0000;
    rd = 32'h0000_0000;

    // two-stage synchroniser on all nine pins
    s_next.sync1 = {fast_pulse_input_i, switch_inputs_one_to_eight_i};
    s_next.sync2 = s_reg.sync1;

    // millisecond prescaler shared by the filter and the delays
    if (tick) begin
      s_next.pre_cnt = 32'h0000_0000;
    end else begin
      s_next.pre_cnt = s_reg.pre_cnt + 32'h0000_0001;
    end

    for (int i = 0; i < NUM_TERM; i++) begin
      // virtual terminals take the link value, the pin is not looked at
      if (s_reg.venable[i]) begin
        src = s_reg.vstate[i];
      end else begin
        src = s_reg.sync2[i];
      end
      // in pulse mode the fast pin feeds the frequency path, not a switch
      if ((i == FAST_IDX) && (s_reg.ftype == FAST_IS_PULSE) && !s_reg.venable[i]) begin
        src = 1'h0;
      end
      // inversion ahead of filter so the delays see the logical level
      raw = src ^ s_reg.pol[i];

      // filter: accept a level only once it held for the full filter time
      if (raw == s_reg.filt[i]) begin
        s_next.fcnt[i] = 16'h0000;
      end else if (s_reg.fcnt[i] >= s_reg.filt_ms) begin
        s_next.filt[i] = raw;
        s_next.fcnt[i] = 16'h0000;
      end else if (tick) begin
        s_next.fcnt[i] = s_reg.fcnt[i] + 16'h0001;
      end

      // switch delay: on delay for a rising change, off delay for a falling one
      dly = s_reg.filt[i] ? s_reg.on_dly[i] : s_reg.off_dly[i];
      if (s_reg.filt[i] == s_reg.term[i]) begin
        s_next.dcnt[i] = 16'h0000;
      end else if (s_reg.dcnt[i] >= dly) begin
        s_next.term[i] = s_reg.filt[i];
        s_next.dcnt[i] = 16'h0000;
      end else if (tick) begin
        s_next.dcnt[i] = s_reg.dcnt[i] + 16'h0001;
      end
    end

    // function decode from the conditioned terminal states
    s_next.func.run_cmd_comm = code_active(s_reg.term, s_reg.fsel, FN_RUN_COMM);
    s_next.func.preexcite = code_active(s_reg.term, s_reg.fsel, FN_PREEXCITE);
    s_next.func.energy_clear = code_active(s_reg.term, s_reg.fsel, FN_ENERGY_CLR);
    s_next.func.energy_hold = code_active(s_reg.term, s_reg.fsel, FN_ENERGY_HOLD);
    s_next.func.brake_limit_keypad = code_active(s_reg.term, s_reg.fsel, FN_BRAKE_KEYPAD);
    // reserved codes match none of these and so do nothing
    s_next.func.emergency_stop = code_active(s_reg.term, s_reg.fsel, FN_ESTOP);
    s_next.func.pid_invert = code_active(s_reg.term, s_reg.fsel, FN_PID_INV);

    // raw fast pin for the pulse counter, only when configured as pulse input
    s_next.fast_pulse = (s_reg.ftype == FAST_IS_PULSE) & s_reg.sync2[FAST_IDX];

    // register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ADDR_POLARITY: s_next.pol = bus_i.wdata[8:0];
        ADDR_FILTER: s_next.filt_ms = clamp_ms(bus_i.wdata, FILTER_MAX_MS);
        ADDR_VIRT_EN: s_next.venable = bus_i.wdata[8:0];
        ADDR_WIRE_MODE: s_next.wmode = wire_mode_t'(bus_i.wdata[1:0]);
        ADDR_FAST_TYPE: s_next.ftype = bus_i.wdata[0];
        ADDR_VIRT_STATE: s_next.vstate = bus_i.wdata[8:0];
        default: begin
          for (int i = 0; i < NUM_TERM; i++) begin
            if (bus_i.addr == word_addr(ADDR_FUNC_BASE, i)) begin
              s_next.fsel[i] = bus_i.wdata[6:0];
            end
            if (bus_i.addr == word_addr(ADDR_ON_BASE, i)) begin
              s_next.on_dly[i] = clamp_ms(bus_i.wdata, DELAY_MAX_MS);
            end
            if (bus_i.addr == word_addr(ADDR_OFF_BASE, i)) begin
              s_next.off_dly[i] = clamp_ms(bus_i.wdata, DELAY_MAX_MS);
            end
          end
        end
      endcase
    end

    // register reads: data valid only in the cycle after the strobe
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_POLARITY: rd = {23'h000000, s_reg.pol};
        ADDR_FILTER: rd = {16'h0000, s_reg.filt_ms};
        ADDR_VIRT_EN: rd = {23'h000000, s_reg.venable};
        ADDR_WIRE_MODE: rd = {30'h00000000, s_reg.wmode};
        ADDR_FAST_TYPE: rd = {31'h00000000, s_reg.ftype};
        ADDR_STATUS: rd = {16'h0000, s_reg.func, s_reg.term};
        ADDR_VIRT_STATE: rd = {23'h000000, s_reg.vstate};
        default: begin
          for (int i = 0; i < NUM_TERM; i++) begin
            if (bus_i.addr == word_addr(ADDR_FUNC_BASE, i)) begin
              rd = {25'h0000000, s_reg.fsel[i]};
            end
            if (bus_i.addr == word_addr(ADDR_ON_BASE, i)) begin
              rd = {16'h0000, s_reg.on_dly[i]};
            end
            if (bus_i.addr == word_addr(ADDR_OFF_BASE, i)) begin
              rd = {16'h0000, s_reg.off_dly[i]};
            end
          end
        end
      endcase
    end
    s_next.rdata = rd;
  end

  // state register with synchronous reset to documented defaults
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
      s_reg.pol <= POLARITY_RST;
      s_reg.venable <= VIRT_EN_RST;
      s_reg.wmode <= TWO_WIRE_ONE;
      s_reg.ftype <= FAST_TYPE_RST;
      s_reg.filt_ms <= FILTER_DEF_MS;
      s_reg.fsel <= {NUM_TERM{FUNC_RST}};
      s_reg.on_dly <= {NUM_TERM{DELAY_RST_MS}};
      s_reg.off_dly <= {NUM_TERM{DELAY_RST_MS}};
    end else begin
      s_reg <= s_next;
    end
  end

  // all outputs come straight from flip-flops
  assign rdata_o = s_reg.rdata;
  assign func_o = s_reg.func;
  assign term_state_o = s_reg.term;
  assign run_wire_mode_o = s_reg.wmode;
  assign fast_input_type_o = s_reg.ftype;
  assign fast_pulse_o = s_reg.fast_pulse;

endmodule // digital_input_conditioning

// *** rtl/dic_pkg.sv ***
// constants and types for the digital input conditioning block
package dic_pkg;

  // register map, byte addresses, word aligned except ADDR_VIRT_STATE (16'h200A)
  localparam logic [15:0] ADDR_POLARITY = 16'h0000;
  localparam logic [15:0] ADDR_FILTER = 16'h0004;
  localparam logic [15:0] ADDR_VIRT_EN = 16'h0008;
  localparam logic [15:0] ADDR_WIRE_MODE = 16'h000C;
  localparam logic [15:0] ADDR_FAST_TYPE = 16'h0010;
  localparam logic [15:0] ADDR_STATUS = 16'h0014;
  localparam logic [15:0] ADDR_FUNC_BASE = 16'h0020;
  localparam logic [15:0] ADDR_ON_BASE = 16'h0060;
  localparam logic [15:0] ADDR_OFF_BASE = 16'h00A0;
  localparam logic [15:0] ADDR_VIRT_STATE = 16'h200A;
  localparam logic [15:0] ADDR_STRIDE = 16'h0004;

  // terminal count: eight switch inputs plus the fast input at index 8
  localparam int NUM_TERM = 9;
  localparam int FAST_IDX = 8;

  // reset values and limits
  localparam logic [8:0] POLARITY_RST = 9'h000;
  localparam logic [8:0] VIRT_EN_RST = 9'h000;
  localparam logic [1:0] WIRE_MODE_RST = 2'h0;
  localparam logic FAST_TYPE_RST = 1'h0;
  localparam logic [6:0] FUNC_RST = 7'h00;
  localparam logic [15:0] DELAY_RST_MS = 16'h0000;

  // timing: filter and delays count in milliseconds
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] FILTER_DEF_MS = 16'h000A;
  localparam logic [15:0] FILTER_MAX_MS = 16'h03E8;
  localparam logic [15:0] DELAY_MAX_MS = 16'hC350;

  // fast input type
  localparam logic FAST_IS_PULSE = 1'h0;
  localparam logic FAST_IS_DIGITAL = 1'h1;

  // function codes acted on here
  localparam logic [6:0] FN_RUN_COMM = 7'h26;
  localparam logic [6:0] FN_PREEXCITE = 7'h27;
  localparam logic [6:0] FN_ENERGY_CLR = 7'h28;
  localparam logic [6:0] FN_ENERGY_HOLD = 7'h29;
  localparam logic [6:0] FN_BRAKE_KEYPAD = 7'h2A;
  localparam logic [6:0] FN_ESTOP = 7'h38;
  localparam logic [6:0] FN_PID_INV = 7'h3D;

  // run control wiring modes
  typedef enum logic [1:0] {
    TWO_WIRE_ONE = 2'b00,
    TWO_WIRE_TWO = 2'b01,
    THREE_WIRE_ONE = 2'b10,
    THREE_WIRE_TWO = 2'b11
  } wire_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic run_cmd_comm;
    logic preexcite;
    logic energy_clear;
    logic energy_hold;
    logic brake_limit_keypad;
    logic emergency_stop;
    logic pid_invert;
  } func_out_t;

  typedef struct packed {
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [8:0] pol;
    logic [8:0] venable;
    logic [8:0] vstate;
    wire_mode_t wmode;
    logic ftype;
    logic [15:0] filt_ms;
    logic [8:0][6:0] fsel;
    logic [8:0][15:0] on_dly;
    logic [8:0][15:0] off_dly;
    logic [31:0] pre_cnt;
    logic [8:0][15:0] fcnt;
    logic [8:0] filt;
    logic [8:0][15:0] dcnt;
    logic [8:0] term;
    func_out_t func;
    logic [31:0] rdata;
    logic fast_pulse;
  } state_t;

endpackage

// *** test/dic_props.sv ***
// assertion checker for the digital input conditioning ports
`timescale 1ns/1ns
module dic_props import dic_pkg::*; #(
  parameter int unsigned MS_CYCLES = 2
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire dic_pkg::bus_req_t bus_i,
  input wire logic [31:0] rdata_o,
  input wire logic [7:0] switch_inputs_one_to_eight_i,
  input wire logic fast_pulse_input_i,
  input wire dic_pkg::func_out_t func_o,
  input wire logic [8:0] term_state_o,
  input wire dic_pkg::wire_mode_t run_wire_mode_o,
  input wire logic fast_input_type_o,
  input wire logic fast_pulse_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // address decodes: wm shared by the three wire mode properties, ft used by a_type_write
  wire wm = bus_i.addr == ADDR_WIRE_MODE;
  wire ft = bus_i.addr == ADDR_FAST_TYPE;

  a_read_idle: assert property (!bus_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside its slot");
  a_mode_write: assert property (
    bus_i.wr && wm |=> run_wire_mode_o == $past(bus_i.wdata[1:0]))
    else $error("wire mode write lost");
  a_mode_hold: assert property (!(bus_i.wr && wm) |=> $stable(run_wire_mode_o))
    else $error("wire mode moved without write");
  a_mode_read: assert property (
    bus_i.rd && wm |=> rdata_o == {30'h0, $past(run_wire_mode_o)})
    else $error("wire mode read wrong");
  a_type_write: assert property (
    bus_i.wr && ft |=> fast_input_type_o == $past(bus_i.wdata[0]))
    else $error("fast type write lost");
  a_fast_quiet: assert property ($past(fast_input_type_o) |-> !fast_pulse_o)
    else $error("pulse output while digital");
  // pin to pulse output is two sync stages plus the output flop
  a_fast_follow: assert property (
    fast_pulse_o == (!$past(fast_input_type_o) && $past(fast_pulse_input_i, 3)))
    else $error("pulse output not following pin");
  a_func_cause: assert property (
    func_o != 7'h00 |-> $past(term_state_o) != 9'h000)
    else $error("function active with no terminal");
  a_status_read: assert property (bus_i.rd && bus_i.addr == ADDR_STATUS |=>
    rdata_o[15:0] == {$past(func_o), $past(term_state_o)})
    else $error("status read wrong");
endmodule // dic_props

bind digital_input_conditioning dic_props #(.MS_CYCLES(MS_CYCLES)) dic_props_inst (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .switch_inputs_one_to_eight_i(switch_inputs_one_to_eight_i),
  .fast_pulse_input_i(fast_pulse_input_i), .func_o(func_o), .term_state_o(term_state_o),
  .run_wire_mode_o(run_wire_mode_o), .fast_input_type_o(fast_input_type_o),
  .fast_pulse_o(fast_pulse_o));

// *** test/switch_model.sv ***
// far-side model: switch contacts and the fast pin
`timescale 1ns/1ns
module switch_model (
  input wire logic mclk_i,
  input wire logic [8:0] level_i,
  output logic [7:0] sw_o = 8'h00,
  output logic fast_o = 1'h0
);
  // contacts move just after an edge, so the pin level is never caught mid-edge
  always_ff @(posedge mclk_i) begin
    sw_o <= level_i[7:0];
    fast_o <= level_i[8];
  end
endmodule // switch_model

// *** test/tb.sv ***
// self-checking bench for the digital input conditioning block
`timescale 1ns/1ns
module tb;
  import dic_pkg::*;
  localparam int unsigned MSC = 2;
  logic mclk_i = 1'h0;
  logic rstn_i = 1'h0;
  bus_req_t bus_i = '0;
  logic [31:0] rdata_o;
  logic [7:0] sw;
  logic fp;
  func_out_t func_o;
  logic [8:0] term_state_o;
  wire_mode_t run_wire_mode_o;
  logic fast_input_type_o;
  logic fast_pulse_o;
  logic [8:0] lv = 9'h000;
  logic [31:0] q;
  int bad_count = 0;
  int tests_run = 0;
  logic [6:0] cd [8] = '{7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h38, 7'h3D, 7'h2B};

  digital_input_conditioning #(.MS_CYCLES(MSC)) digital_input_conditioning_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .switch_inputs_one_to_eight_i(sw), .fast_pulse_input_i(fp), .func_o(func_o),
    .term_state_o(term_state_o), .run_wire_mode_o(run_wire_mode_o),
    .fast_input_type_o(fast_input_type_o), .fast_pulse_o(fast_pulse_o));
  switch_model switch_model_inst (.mclk_i(mclk_i), .level_i(lv), .sw_o(sw), .fast_o(fp));

  initial forever #4 mclk_i = ~mclk_i;

  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // settle past the edge so registered outputs are read after they land
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge mclk_i);
    bus_i.wr <= 1'h0;
  endtask
  task rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge mclk_i);
    bus_i.rd <= 1'h0;
    #1 v = rdata_o;
  endtask
  // bounded wait for a terminal pattern; running out ends the run
  task wt(input logic [8:0] e, input int n);
    #1; // callers may arrive in the edge's own time step
    for (int i = 0; i < n && term_state_o !== e; i++) cyc(1);
    chk({23'h0, term_state_o}, {23'h0, e});
    if (term_state_o !== e) final_report();
  endtask

  task t_reset;
    rd(ADDR_POLARITY, q);
    chk(q, 32'h0);
    rd(ADDR_FILTER, q);
    chk(q, 32'hA);
    rd(ADDR_VIRT_EN, q);
    chk(q, 32'h0);
    rd(ADDR_WIRE_MODE, q);
    chk(q, 32'h0);
    rd(ADDR_FAST_TYPE, q);
    chk(q, 32'h0);
    rd(ADDR_OFF_BASE + 16'h0020, q);
    chk(q, 32'h0);
    rd(16'h0100, q);
    chk(q, 32'h0);
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_WIRE_MODE, 32'(m));
      rd(ADDR_WIRE_MODE, q);
      chk(q, 32'(m));
    end
    lv <= 9'h100;
    cyc(6);
    chk({31'h0, fast_pulse_o}, 32'h1);
    chk({31'h0, term_state_o[8]}, 32'h0);
    wr(ADDR_FAST_TYPE, 32'h1);
    rd(ADDR_FAST_TYPE, q);
    chk(q, 32'h1);
    lv <= 9'h000;
  endtask
  task t_polarity;
    wr(ADDR_FILTER, 32'h1_0000);
    rd(ADDR_FILTER, q);
    chk(q, 32'h3E8);
    wr(ADDR_FILTER, 32'h0);
    wr(ADDR_POLARITY, 32'h3FF);
    rd(ADDR_POLARITY, q);
    chk(q, 32'h1FF);
    wt(9'h1FF, 20);
    wr(ADDR_POLARITY, 32'h0);
    wt(9'h000, 20);
  endtask
  task t_filter;
    wr(ADDR_FILTER, 32'h3);
    lv <= 9'h001;
    cyc(2);
    lv <= 9'h000;
    cyc(14);
    chk({23'h0, term_state_o}, 32'h0);
    lv <= 9'h001;
    cyc(3);
    chk({23'h0, term_state_o}, 32'h0);
    wt(9'h001, 30);
    lv <= 9'h000;
    wt(9'h000, 30);
    wr(ADDR_FILTER, 32'h0);
  endtask
  task t_delay;
    wr(ADDR_ON_BASE, 32'h5);
    lv <= 9'h001;
    cyc(6);
    chk({23'h0, term_state_o}, 32'h0);
    wt(9'h001, 40);
    lv <= 9'h000;
    wt(9'h000, 8);
    wr(ADDR_ON_BASE, 32'h0);
    // off delay holds the terminal on after the pin drops
    wr(ADDR_OFF_BASE, 32'h1_0000);
    rd(ADDR_OFF_BASE, q);
    chk(q, 32'hC350);
    wr(ADDR_OFF_BASE, 32'h5);
    lv <= 9'h001;
    wt(9'h001, 20);
    lv <= 9'h000;
    cyc(6);
    chk({23'h0, term_state_o}, 32'h1);
    wt(9'h000, 40);
    wr(ADDR_OFF_BASE, 32'h0);
  endtask
  task t_virtual;
    wr(ADDR_VIRT_EN, 32'h104);
    lv <= 9'h1FF;
    wt(9'h0FB, 20);
    wr(ADDR_VIRT_STATE, 32'h104);
    wt(9'h1FF, 20);
    lv <= 9'h000;
    wt(9'h104, 20);
    wr(ADDR_VIRT_EN, 32'h0);
    wt(9'h000, 20);
  endtask
  task t_funcs;
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FUNC_BASE, {25'h0, cd[i]});
      lv <= 9'h001;
      wt(9'h001, 20);
      cyc(2);
      chk({25'h0, func_o}, 32'h40 >> i);
      rd(ADDR_STATUS, q);
      chk(q, ((32'h40 >> i) << 9) | 32'h1);
      lv <= 9'h000;
      wt(9'h000, 20);
      cyc(2);
      chk({25'h0, func_o}, 32'h0);
    end
  endtask

  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'h1;
    t_reset();
    t_modes();
    t_polarity();
    t_filter();
    t_delay();
    t_virtual();
    t_funcs();
    final_report();
  end
endmodule // tb
